/* rtl/edm_dest_match.sv */
// Purpose: Packet-memory flag insertion and external destination routing
// Assumes: Lookup logic shares this clock; its bus is a pin, so synchronised
// Notes: Registers reached over AXI4-Lite
module edm_dest_match #(
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_sof,
	input wire logic [3:0] rx_port,
	input wire logic [23:0] rx_fwd_ptr,
	input wire logic rx_word_valid,
	input wire logic [63:0] rx_word_data,
	input wire logic rx_word_last,
	input wire logic [3:0] rx_word_bytes,
	input wire logic [3:0] rx_word_status,
	input wire logic [14:0] internal_dest_map,
	input wire logic internal_dest_bcast,
	input wire logic [15:0] external_dest_lookup,
	output logic mem_ptr_valid,
	output logic [35:0] mem_ptr_word,
	output logic mem_word_valid,
	output logic [63:0] mem_word_data,
	output logic [7:0] mem_word_flag,
	output logic route_valid,
	output logic [14:0] route_map,
	output logic route_discard,
	output logic route_multi_queue
);
	////////////////////////////////////////////////////////////////////////
	// Memory write path with flags
	logic [7:0] word_flag;
	logic first_pending_reg;
	logic ptr_valid_reg;
	logic [35:0] ptr_word_reg;
	logic word_valid_reg;
	logic [63:0] word_data_reg;
	logic [7:0] word_flag_reg;

	edm_flag_gen u_flag (
		.clock(clock),
		.rst(rst),
		.word_valid(rx_word_valid),
		.word_first(first_pending_reg | rx_sof),
		.word_last(rx_word_last),
		.word_bytes(rx_word_bytes),
		.word_status(rx_word_status),
		.word_flag(word_flag)
	);

	// Start flag nibble rides on bits 35-32, port number on 27-24
	wire [35:0] sof_word = {edm_pkg::SOF_NIBBLE, 4'h0, rx_port,
		rx_fwd_ptr};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			first_pending_reg <= 1'b1;
			ptr_valid_reg <= 1'b0;
			ptr_word_reg <= 36'h0;
			word_valid_reg <= 1'b0;
			word_data_reg <= 64'h0;
			word_flag_reg <= 8'h00;
		end else begin
			ptr_valid_reg <= rx_sof;
			if (rx_sof)
				ptr_word_reg <= sof_word;
			if (rx_word_valid)
				first_pending_reg <= 1'b0;
			else if (rx_sof)
				first_pending_reg <= 1'b1;
			word_valid_reg <= rx_word_valid;
			if (rx_word_valid) begin
				word_data_reg <= rx_word_data;
				word_flag_reg <= word_flag;
			end
		end
	end

	assign mem_ptr_valid = ptr_valid_reg;
	assign mem_ptr_word = ptr_word_reg;
	assign mem_word_valid = word_valid_reg;
	assign mem_word_data = word_data_reg;
	assign mem_word_flag = word_flag_reg;

	////////////////////////////////////////////////////////////////////////
	// Lookup bus sampling window
	logic [15:0] lk_meta_reg;
	logic [15:0] lk_sync_reg;
	edm_pkg::edm_state_e state_reg;
	edm_pkg::edm_state_e state_next;
	logic [4:0] win_cnt_reg;
	logic [3:0] src_port_reg;

	wire sample_now = (state_reg == edm_pkg::EDM_WAIT) &
		(win_cnt_reg == 5'(edm_pkg::SAMPLE_CYCLE)) & ~rx_sof;

	always_comb begin
		case (state_reg)
			edm_pkg::EDM_IDLE:
				state_next = rx_sof ? edm_pkg::EDM_WAIT : edm_pkg::EDM_IDLE;
			edm_pkg::EDM_WAIT:
				state_next = rx_sof ? edm_pkg::EDM_WAIT :
					sample_now ? edm_pkg::EDM_HOLD : edm_pkg::EDM_WAIT;
			edm_pkg::EDM_HOLD:
				state_next = rx_sof ? edm_pkg::EDM_WAIT : edm_pkg::EDM_HOLD;
			default:
				state_next = edm_pkg::EDM_IDLE;
		endcase
	end

	// The sync stages add two cycles, so the window count includes them
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lk_meta_reg <= 16'h0;
			lk_sync_reg <= 16'h0;
			state_reg <= edm_pkg::EDM_IDLE;
			win_cnt_reg <= 5'h0;
			src_port_reg <= 4'h0;
		end else begin
			lk_meta_reg <= external_dest_lookup;
			lk_sync_reg <= lk_meta_reg;
			state_reg <= state_next;
			if (rx_sof) begin
				win_cnt_reg <= 5'h0;
				src_port_reg <= rx_port;
			end else if (state_reg == edm_pkg::EDM_WAIT)
				win_cnt_reg <= win_cnt_reg + 5'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Destination selection
	logic form_noop;
	logic form_map;
	logic form_bcast;
	logic [14:0] ext_map;
	logic [31:0] ctrl_reg;
	logic [14:0] virtual_lan_group_reg [edm_pkg::NUM_PORTS];

	edm_dest_decode u_decode (
		.lookup(lk_sync_reg),
		.form_noop(form_noop),
		.form_map(form_map),
		.form_bcast(form_bcast),
		.dest_map(ext_map)
	);

	wire int_en = ctrl_reg[edm_pkg::CTRL_INT_EN_BIT];
	wire single_addr = ctrl_reg[edm_pkg::CTRL_SINGLE_ADDR_BIT];
	// External code wins unless it is the no-op code
	wire use_internal = form_noop;
	wire want_bcast = use_internal ? (int_en & internal_dest_bcast) :
		form_bcast;
	wire [14:0] others = ~(15'h0001 << src_port_reg);
	wire [14:0] virtual_lan_group_limit = single_addr ?
		virtual_lan_group_reg[src_port_reg] : 15'h7fff;
	wire [14:0] bcast_map = others & virtual_lan_group_limit;
	wire [14:0] direct_map = use_internal ?
		(int_en ? internal_dest_map : 15'h0000) : ext_map;
	wire [14:0] sel_map = want_bcast ? bcast_map : direct_map;
	wire sel_discard = (sel_map == 15'h0000);
	wire sel_multi_q = form_map & ~sel_discard;

	logic route_valid_reg;
	logic [14:0] route_map_reg;
	logic route_discard_reg;
	logic route_multi_q_reg;
	logic route_internal_reg;
	logic [31:0] frame_cnt_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			route_valid_reg <= 1'b0;
			route_map_reg <= 15'h0;
			route_discard_reg <= 1'b0;
			route_multi_q_reg <= 1'b0;
			route_internal_reg <= 1'b0;
			frame_cnt_reg <= 32'h0;
		end else begin
			route_valid_reg <= sample_now;
			if (sample_now) begin
				route_map_reg <= sel_map;
				route_discard_reg <= sel_discard;
				route_multi_q_reg <= sel_multi_q;
				route_internal_reg <= use_internal;
				frame_cnt_reg <= frame_cnt_reg + 32'h1;
			end
		end
	end

	assign route_valid = route_valid_reg;
	assign route_map = route_map_reg;
	assign route_discard = route_discard_reg;
	assign route_multi_queue = route_multi_q_reg;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic aw_hold_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic w_hold_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	wire do_write = aw_hold_reg & w_hold_reg;
	wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire [7:0] waddr = 8'(aw_addr_reg);
	wire [7:0] raddr = 8'(s_axi_araddr);
	wire [7:0] wvl_off = waddr - edm_pkg::VIRTUAL_LAN_GROUP_BASE;
	wire [7:0] rvl_off = raddr - edm_pkg::VIRTUAL_LAN_GROUP_BASE;
	wire [3:0] wvl_idx = wvl_off[5:2];
	wire [3:0] rvl_idx = rvl_off[5:2];
	wire w_is_ctrl = (waddr == edm_pkg::CTRL_OFFSET);
	wire w_is_virtual_lan_group = (waddr >= edm_pkg::VIRTUAL_LAN_GROUP_BASE) & (waddr[1:0] == 2'h0) &
		(wvl_off[7:6] == 2'h0) & (wvl_idx < 4'(edm_pkg::NUM_PORTS));
	wire r_is_virtual_lan_group = (raddr >= edm_pkg::VIRTUAL_LAN_GROUP_BASE) & (raddr[1:0] == 2'h0) &
		(rvl_off[7:6] == 2'h0) & (rvl_idx < 4'(edm_pkg::NUM_PORTS));
	wire w_ok = w_is_ctrl | w_is_virtual_lan_group;
	wire [31:0] ctrl_wr = (ctrl_reg & ~wmask) | (w_data_reg & wmask);
	wire [31:0] virtual_lan_group_old = {17'h0, virtual_lan_group_reg[wvl_idx]};
	wire [31:0] virtual_lan_group_wr = (virtual_lan_group_old & ~wmask) | (w_data_reg & wmask);
	wire [31:0] status_word = {13'h0, route_internal_reg,
		route_multi_q_reg, route_discard_reg, 1'b0, route_map_reg};
	wire [31:0] rd_mux = (raddr == edm_pkg::CTRL_OFFSET) ? ctrl_reg :
		(raddr == edm_pkg::STATUS_OFFSET) ? status_word :
		(raddr == edm_pkg::FRAMES_OFFSET) ? frame_cnt_reg :
		r_is_virtual_lan_group ? {17'h0, virtual_lan_group_reg[rvl_idx]} : 32'h0;
	wire r_ok = (raddr == edm_pkg::CTRL_OFFSET) |
		(raddr == edm_pkg::STATUS_OFFSET) |
		(raddr == edm_pkg::FRAMES_OFFSET) | r_is_virtual_lan_group;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= edm_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write)
				aw_hold_reg <= 1'b0;
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write)
				w_hold_reg <= 1'b0;
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= w_ok ? edm_pkg::RESP_OKAY : edm_pkg::RESP_SLVERR;
			end else if (s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg <= edm_pkg::CTRL_RST;
			for (int i = 0; i < edm_pkg::NUM_PORTS; i++)
				virtual_lan_group_reg[i] <= edm_pkg::VIRTUAL_LAN_GROUP_RST;
		end else if (do_write) begin
			if (w_is_ctrl)
				ctrl_reg <= {30'h0, ctrl_wr[1:0]};
			if (w_is_virtual_lan_group)
				virtual_lan_group_reg[wvl_idx] <= virtual_lan_group_wr[14:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= edm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= r_ok ? edm_pkg::RESP_OKAY : edm_pkg::RESP_SLVERR;
		end else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end
endmodule // edm_dest_match

/* rtl/edm_pkg.sv */
// Purpose: Shared constants for the external destination decode block
// Assumes: Single 250 MHz clock, AXI4-Lite register access
// Notes: Register offsets are byte addresses, one 32-bit word each
package edm_pkg;
	localparam int NUM_PORTS = 15;
	localparam int LOOKUP_W = 16;
	localparam int LOOKUP_WINDOW = 12;
	localparam int SYNC_STAGES = 2;
	localparam int SAMPLE_CYCLE = LOOKUP_WINDOW + SYNC_STAGES;
	localparam int BYTES_PER_WORD = 8;
	localparam int BUFFER_BYTES = 64;
	localparam int WORDS_PER_BUF = BUFFER_BYTES / BYTES_PER_WORD;

	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] FRAMES_OFFSET = 8'h08;
	localparam logic [7:0] VIRTUAL_LAN_GROUP_BASE = 8'h40;

	localparam int CTRL_INT_EN_BIT = 0;
	localparam int CTRL_SINGLE_ADDR_BIT = 1;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [14:0] VIRTUAL_LAN_GROUP_RST = 15'h7fff;

	localparam int STAT_DISCARD_BIT = 16;
	localparam int STAT_MULTI_Q_BIT = 17;
	localparam int STAT_INTERNAL_BIT = 18;

	localparam int FLAG_END_BIT = 7;
	localparam int FLAG_EOF_BIT = 3;
	localparam logic [3:0] SOF_NIBBLE = 4'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		EDM_IDLE = 3'h1,
		EDM_WAIT = 3'h2,
		EDM_HOLD = 3'h4
	} edm_state_e;
endpackage

/* rtl/edm_flag_gen.sv */
// Purpose: Builds the flag byte for each eight-byte data word
// Assumes: One word per valid cycle, last word marks end of frame
// Notes: A full word of eight bytes encodes its count as 000
module edm_flag_gen (
	input wire logic clock,
	input wire logic rst,
	input wire logic word_valid,
	input wire logic word_first,
	input wire logic word_last,
	input wire logic [3:0] word_bytes,
	input wire logic [3:0] word_status,
	output logic [7:0] word_flag
);
	logic [2:0] word_cnt_reg;
	logic [2:0] word_cnt_next;
	logic [2:0] cur_cnt;
	wire buf_end = word_last | (cur_cnt == 3'(edm_pkg::WORDS_PER_BUF - 1));
	wire [3:0] low_nib = word_last ? {1'b1, word_status[2:0]} : 4'h0;

	assign cur_cnt = word_first ? 3'h0 : word_cnt_reg;
	assign word_cnt_next = buf_end ? 3'h0 : cur_cnt + 3'h1;
	// Buffer end after every eighth word or at frame end
	assign word_flag = buf_end ?
		{1'b1, word_bytes[2:0], low_nib} : 8'h00;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			word_cnt_reg <= 3'h0;
		else if (word_valid)
			word_cnt_reg <= word_cnt_next;
	end
endmodule // edm_flag_gen

/* rtl/edm_dest_decode.sv */
// Purpose: Decodes the external lookup bus into a destination form
// Assumes: Bus already synchronised; the window sample is taken after decode
// Notes: Purely combinational
module edm_dest_decode (
	input wire logic [15:0] lookup,
	output logic form_noop,
	output logic form_map,
	output logic form_bcast,
	output logic [14:0] dest_map
);
	wire route_form_select = lookup[15];
	wire lookup_noop_line = lookup[4];
	wire [3:0] single_port_code = lookup[3:0];
	wire [14:0] port_map_lines = lookup[14:0];
	wire [14:0] single_map = 15'h0001 << single_port_code;

	assign form_noop = route_form_select & lookup_noop_line;
	assign form_map = ~route_form_select;
	assign form_bcast = route_form_select & ~lookup_noop_line &
		(single_port_code == 4'hf);
	// All-zero bit-map leaves no destination, which discards the frame
	assign dest_map = form_map ? port_map_lines :
		(form_noop | form_bcast) ? 15'h0000 : single_map;
endmodule // edm_dest_decode

/* test/edm_dest_match_chk.sv */
// Purpose: Port-level checks of the destination match block
// Assumes: One clock, asynchronous active-high reset
// Notes: Route lands 16 edges after a frame start, window plus sync
module edm_dest_match_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic rx_sof,
	input wire logic [3:0] rx_port,
	input wire logic [23:0] rx_fwd_ptr,
	input wire logic rx_word_valid,
	input wire logic [63:0] rx_word_data,
	input wire logic rx_word_last,
	input wire logic [3:0] rx_word_bytes,
	input wire logic [3:0] rx_word_status,
	input wire logic mem_ptr_valid,
	input wire logic [35:0] mem_ptr_word,
	input wire logic mem_word_valid,
	input wire logic [63:0] mem_word_data,
	input wire logic [7:0] mem_word_flag,
	input wire logic route_valid,
	input wire logic [14:0] route_map,
	input wire logic route_discard,
	input wire logic route_multi_queue
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
////////////////////////////////////////////////////////////////////////////
	a_ptr_word: assert property (
		rx_sof |=> mem_ptr_valid && mem_ptr_word == {edm_pkg::SOF_NIBBLE,
		4'h0, $past(rx_port), $past(rx_fwd_ptr)}) else $error("bad pointer");
	a_word_pass: assert property (
		rx_word_valid |=> mem_word_valid &&
		mem_word_data == $past(rx_word_data)) else $error("bad word");
	a_flag_eof: assert property (
		rx_word_valid && rx_word_last |=> mem_word_flag == {1'b1,
		3'($past(rx_word_bytes)), 1'b1, 3'($past(rx_word_status))})
		else $error("bad end flag");
	a_eof_cause: assert property (
		mem_word_valid && mem_word_flag[3] |-> $past(rx_word_last))
		else $error("frame end bit on inner word");
	a_flag_plain: assert property (
		mem_word_valid && !mem_word_flag[7] |-> mem_word_flag == 8'h00)
		else $error("flag bits without buffer end");
	a_route_time: assert property (
		rx_sof ##1 !rx_sof [*8] ##1 !rx_sof [*7] |-> ##1 route_valid)
		else $error("route missing at window end");
	a_route_hold: assert property (
		!route_valid |-> $stable(route_map)) else $error("route map moved");
	a_discard: assert property (
		route_valid |-> route_discard == (route_map == 15'h0))
		else $error("discard flag wrong");
	a_multi_q: assert property (
		route_valid && route_multi_queue |-> route_map != 15'h0)
		else $error("multi queue on empty map");
endmodule // edm_dest_match_chk
bind edm_dest_match edm_dest_match_chk u_chk (.clock, .rst, .rx_sof,
	.rx_port, .rx_fwd_ptr, .rx_word_valid, .rx_word_data, .rx_word_last,
	.rx_word_bytes, .rx_word_status, .mem_ptr_valid, .mem_ptr_word,
	.mem_word_valid, .mem_word_data, .mem_word_flag, .route_valid,
	.route_map, .route_discard, .route_multi_queue);

/* test/edm_lookup_model.sv */
// Purpose: Behavioural external lookup logic
// Assumes: Start is the pointer word strobe on the memory bus
// Notes: Code lands dly+1 cycles after start; dly above 10 misses window
module edm_lookup_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic done,
	input wire logic [15:0] code,
	input wire logic [3:0] dly,
	output logic [15:0] lookup
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_reg;
	logic busy_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			lookup <= 16'h9010;
		end else if (start) begin
			busy_reg <= 1'b1;
			cnt_reg <= dly;
		end else if (busy_reg && cnt_reg == 4'h0) begin
			busy_reg <= 1'b0;
			lookup <= code;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg - 4'h1;
		end else if (done) begin
			// Hold time over: stale code must not pass for a valid one
			lookup <= ~code;
		end
	end
endmodule // edm_lookup_model

/* test/edm_dest_match_tb.sv */
// Purpose: Self-checking bench for the destination match block
// Assumes: Lookup model answers inside the 12-cycle window
// Notes: Seeded random traffic mixed with corner codes
module edm_dest_match_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_sof, rx_word_valid;
	logic rx_word_last, internal_dest_bcast, ibc, mem_ptr_valid;
	logic mem_word_valid, route_valid, route_discard, route_multi_queue;
	logic [7:0] s_axi_awaddr, s_axi_araddr, mem_word_flag;
	logic [31:0] s_axi_wdata, s_axi_rdata, ctrl, last_st;
	logic [3:0] s_axi_wstrb, rx_port, rx_word_bytes, rx_word_status, mdl_dly;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [23:0] rx_fwd_ptr;
	logic [63:0] rx_word_data, mem_word_data;
	logic [14:0] internal_dest_map, route_map, imap;
	logic [14:0] virtual_lan_group [15];
	logic [15:0] external_dest_lookup, mdl_code;
	logic [35:0] mem_ptr_word;
	logic [7:0] exp_q [$];
	logic [15:0] corner [5] = '{16'h9010, 16'h0000, 16'h4081, 16'h0004,
		16'h800e};
	int error_cnt, checked, nfr;
	edm_dest_match #(.ADDR_W(8)) uut (.clock, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_sof,
		.rx_port, .rx_fwd_ptr, .rx_word_valid, .rx_word_data, .rx_word_last,
		.rx_word_bytes, .rx_word_status, .internal_dest_map,
		.internal_dest_bcast, .external_dest_lookup, .mem_ptr_valid,
		.mem_ptr_word, .mem_word_valid, .mem_word_data, .mem_word_flag,
		.route_valid, .route_map, .route_discard, .route_multi_queue);
	edm_lookup_model mdl (.clock, .rst, .start(mem_ptr_valid),
		.done(route_valid), .code(mdl_code), .dly(mdl_dly),
		.lookup(external_dest_lookup));
////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Ready is judged at the negedge so the sampling edge never races
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ah, wh, bd;
		bd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 60 && !bd; n++) begin
			@(negedge clock);
			ah = s_axi_awvalid && s_axi_awready === 1'b1;
			wh = s_axi_wvalid && s_axi_wready === 1'b1;
			bd = s_axi_bvalid === 1'b1;
			if (bd)
				chk(36'(s_axi_bresp), 36'(er));
			@(posedge clock);
			if (ah)
				s_axi_awvalid <= 1'b0;
			if (wh)
				s_axi_wvalid <= 1'b0;
		end
		chk(36'(bd), 36'h1);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ah, rd;
		rd = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 60 && !rd; n++) begin
			@(negedge clock);
			ah = s_axi_arvalid && s_axi_arready === 1'b1;
			rd = s_axi_rvalid === 1'b1;
			if (rd)
				chk({2'h0, s_axi_rdata, s_axi_rresp}, {2'h0, ed, er});
			@(posedge clock);
			if (ah)
				s_axi_arvalid <= 1'b0;
		end
		chk(36'(rd), 36'h1);
	endtask
////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_flag(logic [3:0] k, logic [3:0] b,
		logic [3:0] s, logic l);
		if (k != 4'h7 && !l)
			return 8'h00;
		return {1'b1, b[2:0], l, l ? s[2:0] : 3'h0};
	endfunction
	function automatic logic [14:0] exp_map(logic [15:0] lk, logic [3:0] src);
		logic [14:0] b;
		b = 15'h7fff & ~(15'h1 << src);
		if (ctrl[1])
			b = b & virtual_lan_group[src];
		if (!lk[15])
			return lk[14:0];
		if (!lk[4])
			return lk[3:0] == 4'hf ? b : 15'h1 << lk[3:0];
		if (!ctrl[0])
			return 15'h0;
		return ibc ? b : imap;
	endfunction
	always @(negedge clock)
		if (mem_word_valid === 1'b1)
			chk(36'(mem_word_flag), 36'(exp_q.pop_front()));
	task automatic send_frame(input int nw);
		logic [3:0] k, b, s;
		logic l;
		k = 4'h0;
		rx_sof <= 1'b1;
		rx_port <= 4'($urandom_range(0, 14));
		rx_fwd_ptr <= 24'($urandom);
		for (int i = 0; i < nw; i++) begin
			l = i == nw - 1;
			b = l ? 4'($urandom_range(1, 8)) : 4'h8;
			s = 4'($urandom);
			rx_word_status <= s;
			exp_q.push_back(exp_flag(k, b, s, l));
			k = (k == 4'h7 || l) ? 4'h0 : k + 4'h1;
			rx_word_valid <= 1'b1;
			rx_word_data <= {$urandom, $urandom};
			rx_word_last <= l;
			rx_word_bytes <= b;
			#0 @(posedge clock);
			rx_sof <= 1'b0;
		end
		rx_word_valid <= 1'b0;
		nfr++;
		repeat (20) @(posedge clock);
	endtask
	task automatic route_frame(input logic [15:0] lk);
		logic [3:0] src;
		logic [35:0] g, e;
		src = 4'($urandom_range(0, 14));
		imap = 15'($urandom);
		ibc = 1'($urandom);
		e = {19'h0, exp_map(lk, src), 2'h0};
		e[1] = e[16:2] == 15'h0;
		e[0] = !lk[15] && !e[1];
		last_st = {13'h0, lk[15] & lk[4], e[0], e[1], 1'b0, e[16:2]};
		mdl_code <= lk;
		mdl_dly <= 4'($urandom_range(0, 8));
		rx_port <= src;
		internal_dest_map <= imap;
		internal_dest_bcast <= ibc;
		rx_sof <= 1'b1;
		@(posedge clock);
		rx_sof <= 1'b0;
		for (int n = 0; n < 40 && route_valid !== 1'b1; n++)
			@(negedge clock);
		chk(36'(route_valid === 1'b1), 36'h1);
		g = {19'h0, route_map, route_discard, route_multi_queue};
		chk(g, e);
		nfr++;
		@(posedge clock);
	endtask
////////////////////////////////////////////////////////////////////////////
	initial begin
		#40us;
		error_cnt++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		conclude();
	end
	initial begin
		void'($urandom(32'h2ff80113));
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rx_sof} = '0;
		{rx_word_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{rx_port, rx_fwd_ptr, rx_word_data, rx_word_last} = '0;
		{rx_word_bytes, rx_word_status, internal_dest_map} = '0;
		{internal_dest_bcast, mdl_code, mdl_dly} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		ctrl = 32'h1;
		foreach (virtual_lan_group[p])
			virtual_lan_group[p] = 15'h7fff;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		axi_rd(8'h00, ctrl, edm_pkg::RESP_OKAY);
		for (int p = 0; p < 15; p++)
			axi_rd(8'(8'h40 + 4 * p), 32'h7fff, edm_pkg::RESP_OKAY);
		axi_rd(8'h3c, 32'h0, edm_pkg::RESP_SLVERR);
		axi_wr(8'h04, 32'h1, edm_pkg::RESP_SLVERR);
		axi_wr(8'h3c, 32'h2, edm_pkg::RESP_SLVERR);
		axi_rd(8'h00, ctrl, edm_pkg::RESP_OKAY);
		$display("test registers done");
		send_frame(17);
		send_frame(8);
		send_frame(1);
		send_frame($urandom_range(2, 20));
		$display("test flags done");
		for (int c = 0; c < 3; c++) begin
			for (int i = 0; i < 26; i++)
				route_frame(i < 16 ? 16'h8000 | 16'(i) :
					i < 21 ? corner[i - 16] : 16'($urandom));
			ctrl = c == 0 ? 32'h3 : 32'h2;
			axi_wr(8'h00, ctrl, edm_pkg::RESP_OKAY);
			for (int p = 0; p < 15; p++) begin
				virtual_lan_group[p] = 15'($urandom);
				axi_wr(8'(8'h40 + 4 * p), {17'h0, virtual_lan_group[p]}, edm_pkg::RESP_OKAY);
			end
		end
		axi_rd(8'h44, {17'h0, virtual_lan_group[1]}, edm_pkg::RESP_OKAY);
		axi_rd(8'h04, last_st, edm_pkg::RESP_OKAY);
		axi_rd(8'h08, 32'(nfr), edm_pkg::RESP_OKAY);
		$display("test routing done");
		conclude();
	end
endmodule // edm_dest_match_tb
